/* File: aad_alu.sv */
// Combinational arithmetic, logic and decimal adjust of the accumulator
`timescale 1ns/1ps
module aad_alu (
    input wire aad_pkg::aad_op_t op_i,
    input wire aad_pkg::aad_state_t cur_i,
    input wire logic [7:0] operand_i,
    output aad_pkg::aad_state_t nxt_o
);
    logic [7:0] a;
    logic [7:0] r;
    logic cin;
    logic [8:0] full;
    logic [4:0] low;
    logic lo_gt9;
    logic hi_gt9;
    logic hi_ge9;
    logic [7:0] corr;
    aad_pkg::aad_flags_t f;

    assign a = cur_i.acc;
    assign lo_gt9 = a[3:0] > 4'h9;
    assign hi_gt9 = a[7:4] > 4'h9;
    assign hi_ge9 = a[7:4] > 4'h8;

    // Operation select and flag update
    always_comb begin
        f = cur_i.flags;
        r = a;
        full = 9'h000;
        low = 5'h00;
        corr = 8'h00;
        cin = (op_i == aad_pkg::OP_ADC || op_i == aad_pkg::OP_SUBB)
              ? cur_i.flags.c : 1'b0;
        case (op_i)
            aad_pkg::OP_SETC: begin
                f.c = 1'b1;
                f.h = 1'b0;
                f.n = 1'b0;
            end
            aad_pkg::OP_DADJ: begin
                if (!cur_i.flags.n) begin
                    if (lo_gt9 || cur_i.flags.h)
                        corr[3:0] = 4'h6;
                    if (cur_i.flags.c || hi_gt9 || (hi_ge9 && lo_gt9))
                        corr[7:4] = 4'h6;
                    f.c = corr[7:4] != 4'h0;
                    f.h = lo_gt9;
                end else begin
                    case ({cur_i.flags.c, cur_i.flags.h})
                        2'b00: corr = 8'h00;
                        2'b01: corr = 8'hFA;
                        2'b10: corr = 8'hA0;
                        default: corr = 8'h9A;
                    endcase
                    f.h = cur_i.flags.h && (a[3:0] < 4'h6);
                end
                r = a + corr;
                f.pv = ~^r;
            end
            aad_pkg::OP_ADD, aad_pkg::OP_ADC: begin
                full = {1'b0, a} + {1'b0, operand_i} + {8'h00, cin};
                low = {1'b0, a[3:0]} + {1'b0, operand_i[3:0]} + {4'h0, cin};
                r = full[7:0];
                f.c = full[8];
                f.h = low[4];
                f.n = 1'b0;
                f.pv = (a[7] == operand_i[7]) && (r[7] != a[7]);
            end
            aad_pkg::OP_SUB, aad_pkg::OP_SUBB: begin
                full = {1'b0, a} - {1'b0, operand_i} - {8'h00, cin};
                low = {1'b0, a[3:0]} - {1'b0, operand_i[3:0]} - {4'h0, cin};
                r = full[7:0];
                f.c = full[8];
                f.h = low[4];
                f.n = 1'b1;
                f.pv = (a[7] != operand_i[7]) && (r[7] != a[7]);
            end
            aad_pkg::OP_AND: begin
                r = a & operand_i;
                f.h = 1'b1;
                f.n = 1'b0;
                f.c = 1'b0;
                f.pv = ~^r;
            end
            aad_pkg::OP_OR: begin
                r = a | operand_i;
                f.h = 1'b0;
                f.n = 1'b0;
                f.c = 1'b0;
                f.pv = ~^r;
            end
            default: begin
                r = a;
            end
        endcase
        if (op_i != aad_pkg::OP_SETC) begin
            f.s = r[7];
            f.z = r == 8'h00;
        end
        nxt_o.acc = r;
        nxt_o.flags = f;
    end

endmodule

/* File: aad_core.sv */
// Accumulator ALU with decimal adjust behind an Avalon-MM register slave
`timescale 1ns/1ps
module aad_core (
    input wire logic clk_i,
    input wire logic rst_n_i,
    input wire logic [4:0] avs_address_i,
    input wire logic avs_read_i,
    input wire logic avs_write_i,
    input wire logic [3:0] avs_byteenable_i,
    input wire logic [31:0] avs_writedata_i,
    output logic [31:0] avs_readdata_o,
    output logic avs_waitrequest_o,
    output logic [7:0] acc_o,
    output logic [7:0] flags_o,
    output logic busy_o,
    output logic done_o
);
    typedef enum logic {ST_IDLE, ST_EXEC} aad_state_e_t;

    aad_state_e_t state_reg;
    aad_pkg::aad_state_t cpu_reg;
    aad_pkg::aad_state_t alu_next;
    aad_pkg::aad_op_t op_reg;
    logic [7:0] operand_reg;
    logic [7:0] cmd_reg;
    logic [3:0] tcnt_reg;
    logic [3:0] div_reg;
    logic illegal_reg;
    logic ack_reg;
    logic done_reg;
    logic [31:0] rdata_reg;
    logic req;
    logic stall;
    logic wr_take;
    logic t_en;
    logic commit;
    logic cmd_ok;
    aad_pkg::aad_op_t cmd_op;
    logic [3:0] cmd_len;

    ////////////////////////////////////////////////////////////////////////
    // Bus handshake: one wait cycle, writes stall while executing
    assign req = avs_read_i | avs_write_i;
    assign stall = avs_write_i && (state_reg == ST_EXEC);
    assign avs_waitrequest_o = req & ~ack_reg;
    assign wr_take = avs_write_i & ack_reg & avs_byteenable_i[0];

    // Acknowledge after one cycle unless stalled
    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            ack_reg <= 1'b0;
        end else begin
            ack_reg <= req & ~ack_reg & ~stall;
        end
    end

    // Read data captured in the wait cycle
    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            rdata_reg <= 32'h0000_0000;
        end else if (avs_read_i && !ack_reg) begin
            case (avs_address_i)
                aad_pkg::OFS_ACC:
                    rdata_reg <= {24'h000000, cpu_reg.acc};
                aad_pkg::OFS_FLAGS:
                    rdata_reg <= {24'h000000,
                                  aad_pkg::flags_to_byte(cpu_reg.flags)};
                aad_pkg::OFS_OPERAND:
                    rdata_reg <= {24'h000000, operand_reg};
                aad_pkg::OFS_CMD:
                    rdata_reg <= {24'h000000, cmd_reg};
                aad_pkg::OFS_STATUS: begin
                    rdata_reg <= 32'h0000_0000;
                    rdata_reg[aad_pkg::STS_BUSY] <= state_reg == ST_EXEC;
                    rdata_reg[aad_pkg::STS_ILLEGAL] <= illegal_reg;
                    rdata_reg[aad_pkg::STS_TCNT_LSB +: 4] <= tcnt_reg;
                end
                default:
                    rdata_reg <= 32'h0000_0000;
            endcase
        end
    end
    assign avs_readdata_o = rdata_reg;

    ////////////////////////////////////////////////////////////////////////
    // T-state enable from clock divider
    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            div_reg <= 4'h0;
        end else if (state_reg == ST_IDLE || t_en) begin
            div_reg <= 4'h0;
        end else begin
            div_reg <= div_reg + 4'h1;
        end
    end
    assign t_en = (state_reg == ST_EXEC)
                  && (div_reg == aad_pkg::TSTATE_CYC - 4'h1);

    ////////////////////////////////////////////////////////////////////////
    // Opcode decode
    always_comb begin
        cmd_ok = 1'b1;
        cmd_op = aad_pkg::OP_SETC;
        cmd_len = aad_pkg::TST_IMM;
        case (avs_writedata_i[7:0])
            aad_pkg::OPC_SETC: begin
                cmd_op = aad_pkg::OP_SETC;
                cmd_len = aad_pkg::TST_SHORT;
            end
            aad_pkg::OPC_DADJ: begin
                cmd_op = aad_pkg::OP_DADJ;
                cmd_len = aad_pkg::TST_SHORT;
            end
            aad_pkg::OPC_ADD: cmd_op = aad_pkg::OP_ADD;
            aad_pkg::OPC_ADC: cmd_op = aad_pkg::OP_ADC;
            aad_pkg::OPC_SUB: cmd_op = aad_pkg::OP_SUB;
            aad_pkg::OPC_SUBB: cmd_op = aad_pkg::OP_SUBB;
            aad_pkg::OPC_AND: cmd_op = aad_pkg::OP_AND;
            aad_pkg::OPC_OR: cmd_op = aad_pkg::OP_OR;
            default: cmd_ok = 1'b0;
        endcase
    end

    ////////////////////////////////////////////////////////////////////////
    // Execution state and T-state count
    assign commit = (state_reg == ST_EXEC) && t_en && (tcnt_reg == 4'h1);

    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            state_reg <= ST_IDLE;
            tcnt_reg <= 4'h0;
        end else begin
            case (state_reg)
                ST_IDLE: begin
                    if (wr_take && avs_address_i == aad_pkg::OFS_CMD
                        && cmd_ok) begin
                        state_reg <= ST_EXEC;
                        tcnt_reg <= cmd_len;
                    end
                end
                ST_EXEC: begin
                    if (commit) begin
                        state_reg <= ST_IDLE;
                        tcnt_reg <= 4'h0;
                    end else if (t_en) begin
                        tcnt_reg <= tcnt_reg - 4'h1;
                    end
                end
                default: begin
                    state_reg <= ST_IDLE;
                    tcnt_reg <= 4'h0;
                end
            endcase
        end
    end

    // Command capture and sticky illegal opcode flag
    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            op_reg <= aad_pkg::OP_SETC;
            cmd_reg <= aad_pkg::CMD_RST;
            illegal_reg <= 1'b0;
        end else if (wr_take && avs_address_i == aad_pkg::OFS_CMD) begin
            cmd_reg <= avs_writedata_i[7:0];
            op_reg <= cmd_op;
            if (!cmd_ok)
                illegal_reg <= 1'b1;
        end else if (wr_take && avs_address_i == aad_pkg::OFS_STATUS
                     && avs_writedata_i[aad_pkg::STS_ILLEGAL]) begin
            illegal_reg <= 1'b0;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Datapath
    aad_alu u_aad_alu (
        .op_i(op_reg),
        .cur_i(cpu_reg),
        .operand_i(operand_reg),
        .nxt_o(alu_next)
    );

    // Operand byte following the opcode
    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            operand_reg <= aad_pkg::OPERAND_RST;
        end else if (wr_take && avs_address_i == aad_pkg::OFS_OPERAND) begin
            operand_reg <= avs_writedata_i[7:0];
        end
    end

    // Accumulator and flags: software load or commit
    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            cpu_reg.acc <= aad_pkg::ACC_RST;
            cpu_reg.flags <= aad_pkg::FLAGS_RST;
        end else if (commit) begin
            cpu_reg <= alu_next;
        end else if (wr_take && avs_address_i == aad_pkg::OFS_ACC) begin
            cpu_reg.acc <= avs_writedata_i[7:0];
        end else if (wr_take && avs_address_i == aad_pkg::OFS_FLAGS) begin
            cpu_reg.flags <= aad_pkg::byte_to_flags(avs_writedata_i[7:0]);
        end
    end

    // Completion pulse
    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            done_reg <= 1'b0;
        end else begin
            done_reg <= commit;
        end
    end

    assign acc_o = cpu_reg.acc;
    assign flags_o = aad_pkg::flags_to_byte(cpu_reg.flags);
    assign busy_o = state_reg == ST_EXEC;
    assign done_o = done_reg;

    ////////////////////////////////////////////////////////////////////////
    // Assertions
    default clocking cb @(posedge clk_i);
    endclocking
    default disable iff (!rst_n_i);

    logic [7:0] a_q;
    logic [7:0] n_q;
    aad_pkg::aad_flags_t f_q;

    // Operands seen when execution starts
    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            a_q <= 8'h00;
            n_q <= 8'h00;
            f_q <= aad_pkg::FLAGS_RST;
        end else if (state_reg == ST_IDLE) begin
            a_q <= cpu_reg.acc;
            n_q <= operand_reg;
            f_q <= cpu_reg.flags;
        end
    end

    property p_setc;
        done_reg && op_reg == aad_pkg::OP_SETC |->
            cpu_reg.flags.c && !cpu_reg.flags.h && !cpu_reg.flags.n
            && cpu_reg.acc == a_q && cpu_reg.flags.z == f_q.z;
    endproperty
    a_setc: assert property (p_setc)
        else $error("set carry flags wrong");

    property p_short_len;
        $rose(busy_o) && (op_reg == aad_pkg::OP_SETC
                          || op_reg == aad_pkg::OP_DADJ)
            |-> busy_o [*4] ##1 !busy_o;
    endproperty
    a_short_len: assert property (p_short_len)
        else $error("short op length wrong");

    property p_imm_len;
        $rose(busy_o) && op_reg != aad_pkg::OP_SETC
            && op_reg != aad_pkg::OP_DADJ |-> busy_o [*7] ##1 !busy_o;
    endproperty
    a_imm_len: assert property (p_imm_len)
        else $error("immediate op length wrong");

    property p_dadj_add;
        done_reg && op_reg == aad_pkg::OP_DADJ && !f_q.n
            && !f_q.c && !f_q.h && a_q[7:4] < 4'h9 && a_q[3:0] > 4'h9
            |-> cpu_reg.acc == a_q + 8'h06 && !cpu_reg.flags.c;
    endproperty
    a_dadj_add: assert property (p_dadj_add)
        else $error("additive adjust wrong");

    property p_dadj_sub;
        done_reg && op_reg == aad_pkg::OP_DADJ && f_q.n
            |-> cpu_reg.flags.n && cpu_reg.flags.c == f_q.c;
    endproperty
    a_dadj_sub: assert property (p_dadj_sub)
        else $error("subtractive adjust carry wrong");

    property p_add;
        done_reg && op_reg == aad_pkg::OP_ADD
            |-> cpu_reg.acc == a_q + n_q && !cpu_reg.flags.n
                && cpu_reg.flags.z == (cpu_reg.acc == 8'h00);
    endproperty
    a_add: assert property (p_add)
        else $error("add result wrong");

    property p_subb;
        done_reg && op_reg == aad_pkg::OP_SUBB
            |-> cpu_reg.acc == a_q - n_q - {7'h00, f_q.c}
                && cpu_reg.flags.n;
    endproperty
    a_subb: assert property (p_subb)
        else $error("subtract with borrow wrong");

    property p_and;
        done_reg && op_reg == aad_pkg::OP_AND
            |-> cpu_reg.acc == (a_q & n_q) && cpu_reg.flags.h
                && !cpu_reg.flags.c && cpu_reg.flags.pv == ~^cpu_reg.acc;
    endproperty
    a_and: assert property (p_and)
        else $error("and flags wrong");

    property p_or;
        done_reg && op_reg == aad_pkg::OP_OR
            |-> cpu_reg.acc == (a_q | n_q) && !cpu_reg.flags.h
                && cpu_reg.flags.s == cpu_reg.acc[7];
    endproperty
    a_or: assert property (p_or)
        else $error("or result wrong");

    c_dadj: cover property (done_reg && op_reg == aad_pkg::OP_DADJ);
    c_subb_borrow: cover property (done_reg && op_reg == aad_pkg::OP_SUBB
                                   && cpu_reg.flags.c);
    c_stall: cover property (avs_write_i && busy_o && avs_waitrequest_o);
    c_illegal: cover property ($rose(illegal_reg));

endmodule

/* File: aad_core_tb.sv */
// Self-checking bench of the accumulator ALU register slave
`timescale 1ns/1ps
module aad_core_tb;
    logic clk_i = 1'b0;
    logic rst_n_i = 1'b0;
    logic [4:0] avs_address_i = 5'h00;
    logic avs_read_i = 1'b0;
    logic avs_write_i = 1'b0;
    logic [3:0] avs_byteenable_i = 4'hF;
    logic [31:0] avs_writedata_i = 32'h00000000;
    logic [31:0] avs_readdata_o;
    logic avs_waitrequest_o;
    logic [7:0] acc_o;
    logic [7:0] flags_o;
    logic busy_o;
    logic done_o;
    int n_fail = 0;
    int check_count = 0;
    logic [31:0] rd;
    logic [15:0] ex;
    logic [7:0] e_acc;
    logic [7:0] e_flg;
    int cyc;
    int e_len;

    // Case table: opcode, acc, flags (FF keeps last result), operand
    localparam int NC = 25;
    localparam logic [31:0] TB [NC] = '{
        {aad_pkg::OPC_SETC, 24'h55D600}, {aad_pkg::OPC_ADD, 24'h7F0101},
        {aad_pkg::OPC_ADD, 24'hFF0001}, {aad_pkg::OPC_ADC, 24'h380145},
        {aad_pkg::OPC_SUB, 24'h000001}, {aad_pkg::OPC_SUBB, 24'h800100},
        {aad_pkg::OPC_SUB, 24'h451345}, {aad_pkg::OPC_AND, 24'hF0033C},
        {aad_pkg::OPC_OR, 24'h001300}, {aad_pkg::OPC_OR, 24'h810002},
        {aad_pkg::OPC_DADJ, 24'h990000}, {aad_pkg::OPC_DADJ, 24'h8A0000},
        {aad_pkg::OPC_DADJ, 24'h921000}, {aad_pkg::OPC_DADJ, 24'hA50000},
        {aad_pkg::OPC_DADJ, 24'h9B0000}, {aad_pkg::OPC_DADJ, 24'hB21000},
        {aad_pkg::OPC_DADJ, 24'h250100}, {aad_pkg::OPC_DADJ, 24'h1C0100},
        {aad_pkg::OPC_DADJ, 24'h321100}, {aad_pkg::OPC_DADJ, 24'h450200},
        {aad_pkg::OPC_DADJ, 24'h3F1200}, {aad_pkg::OPC_DADJ, 24'h850300},
        {aad_pkg::OPC_DADJ, 24'h991300}, {aad_pkg::OPC_ADD, 24'h380045},
        {aad_pkg::OPC_DADJ, 24'h00FF00}
    };

    ////////////////////////////////////////////////////////////////////////
    // Clock and design
    always #5 clk_i = ~clk_i;

    aad_core u_aad_core (
        .clk_i(clk_i),
        .rst_n_i(rst_n_i),
        .avs_address_i(avs_address_i),
        .avs_read_i(avs_read_i),
        .avs_write_i(avs_write_i),
        .avs_byteenable_i(avs_byteenable_i),
        .avs_writedata_i(avs_writedata_i),
        .avs_readdata_o(avs_readdata_o),
        .avs_waitrequest_o(avs_waitrequest_o),
        .acc_o(acc_o),
        .flags_o(flags_o),
        .busy_o(busy_o),
        .done_o(done_o)
    );

    ////////////////////////////////////////////////////////////////////////
    // Verdict and comparison
    task automatic close_out();
        $display("Checks %0d, mismatches %0d", check_count, n_fail);
        if (n_fail == 0 && check_count > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask

    task automatic check(input string what, input logic [31:0] seen,
                         input logic [31:0] exp);
        check_count++;
        if (seen !== exp) begin
            n_fail++;
            $display("MISMATCH %s expected %h seen %h", what, exp, seen);
        end
    endtask

    ////////////////////////////////////////////////////////////////////////
    // Bus master: hold request until waitrequest low, then release
    task automatic bus(input logic wr, input logic [4:0] adr,
                       input logic [7:0] d, input logic [3:0] be);
        int k;
        k = 0;
        @(posedge clk_i);
        avs_address_i <= adr;
        avs_writedata_i <= {24'hFFFFFF, d};
        avs_byteenable_i <= be;
        avs_write_i <= wr;
        avs_read_i <= ~wr;
        // Waitrequest and read data taken at the rising edge only
        do begin
            @(posedge clk_i);
            k++;
        end while (avs_waitrequest_o !== 1'b0 && k < 60);
        if (avs_waitrequest_o !== 1'b0) begin
            n_fail++;
            close_out();
        end
        rd = avs_readdata_o;
        avs_write_i <= 1'b0;
        avs_read_i <= 1'b0;
    endtask

    ////////////////////////////////////////////////////////////////////////
    // Reference result {acc, flags} worked out independently
    function automatic logic [15:0] model(input logic [7:0] o,
        input logic [7:0] a, input logic [7:0] f, input logic [7:0] n);
        logic [8:0] r;
        logic [7:0] cr;
        logic h, c, nf, v, ci;
        ci = f[0] & (o == aad_pkg::OPC_ADC || o == aad_pkg::OPC_SUBB);
        h = 1'b0;
        c = 1'b0;
        nf = 1'b0;
        r = {1'b0, a};
        if (o == aad_pkg::OPC_SETC) begin
            return {a, (f & 8'hC4) | 8'h01};
        end
        if (o == aad_pkg::OPC_ADD || o == aad_pkg::OPC_ADC) begin
            r = {1'b0, a} + {1'b0, n} + 9'(ci);
            h = ({1'b0, a[3:0]} + {1'b0, n[3:0]} + 5'(ci)) > 5'h0F;
            c = r[8];
        end else if (o == aad_pkg::OPC_SUB || o == aad_pkg::OPC_SUBB) begin
            r = {1'b0, a} - {1'b0, n} - 9'(ci);
            h = {1'b0, a[3:0]} < ({1'b0, n[3:0]} + 5'(ci));
            c = r[8];
            nf = 1'b1;
        end else if (o == aad_pkg::OPC_AND) begin
            r = {1'b0, a & n};
            h = 1'b1;
        end else if (o == aad_pkg::OPC_OR) begin
            r = {1'b0, a | n};
        end else if (!f[1]) begin
            c = f[0] || a[7:4] > 4'h9 || (a[7:4] >= 4'h9 && a[3:0] > 4'h9);
            cr = (c ? 8'h60 : 8'h00)
                 + ((f[4] || a[3:0] > 4'h9) ? 8'h06 : 8'h00);
            h = a[3:0] > 4'h9;
            r = {1'b0, a + cr};
        end else begin
            c = f[0];
            cr = (f[0] ? 8'hA0 : 8'h00) + (f[4] ? 8'hFA : 8'h00);
            h = f[4] && a[3:0] < 4'h6;
            nf = 1'b1;
            r = {1'b0, a + cr};
        end
        if (o == aad_pkg::OPC_ADD || o == aad_pkg::OPC_ADC) begin
            v = (a[7] == n[7]) && (r[7] != a[7]);
        end else if (o == aad_pkg::OPC_SUB || o == aad_pkg::OPC_SUBB) begin
            v = (a[7] != n[7]) && (r[7] != a[7]);
        end else begin
            v = ~^r[7:0];
        end
        return {r[7:0], r[7], r[7:0] == 8'h00, 1'b0, h, 1'b0, v, nf, c};
    endfunction

    ////////////////////////////////////////////////////////////////////////
    // Main sequence
    initial begin
        repeat (20) @(posedge clk_i);
        rst_n_i <= 1'b1;
        // Reset values and unmapped place
        bus(1'b0, aad_pkg::OFS_ACC, 8'h00, 4'hF);
        check("acc reset", rd, 32'h00000000);
        bus(1'b0, aad_pkg::OFS_FLAGS, 8'h00, 4'hF);
        check("flags reset", rd, 32'h00000000);
        bus(1'b0, 5'h14, 8'h00, 4'hF);
        check("unmapped read", rd, 32'h00000000);
        bus(1'b1, aad_pkg::OFS_ACC, 8'h5A, 4'h0);
        bus(1'b1, aad_pkg::OFS_ACC, 8'hA5, 4'hF);
        bus(1'b0, aad_pkg::OFS_ACC, 8'h00, 4'hF);
        check("acc lane", rd, 32'h000000A5);
        // Unknown opcode refused, sticky until cleared
        bus(1'b1, aad_pkg::OFS_CMD, 8'h00, 4'hF);
        bus(1'b0, aad_pkg::OFS_STATUS, 8'h00, 4'hF);
        check("illegal set", rd & 32'h3, 32'h00000002);
        check("acc kept", {24'h0, acc_o}, 32'h000000A5);
        bus(1'b1, aad_pkg::OFS_STATUS, 8'h02, 4'hF);
        bus(1'b0, aad_pkg::OFS_STATUS, 8'h00, 4'hF);
        check("illegal clr", rd & 32'h3, 32'h00000000);
        // Write during execution stalls, then lands after commit
        bus(1'b1, aad_pkg::OFS_CMD, aad_pkg::OPC_SETC, 4'hF);
        bus(1'b1, aad_pkg::OFS_ACC, 8'h3C, 4'hF);
        check("stall busy", {31'h0, busy_o}, 32'h0);
        bus(1'b0, aad_pkg::OFS_ACC, 8'h00, 4'hF);
        check("stall acc", rd, 32'h0000003C);
        bus(1'b0, aad_pkg::OFS_FLAGS, 8'h00, 4'hF);
        check("stall flags", rd, 32'h00000001);
        for (int i = 0; i < NC; i++) begin
            if (TB[i][15:8] != 8'hFF) begin
                e_acc = TB[i][23:16];
                e_flg = TB[i][15:8];
                bus(1'b1, aad_pkg::OFS_ACC, e_acc, 4'hF);
                bus(1'b1, aad_pkg::OFS_FLAGS, e_flg, 4'hF);
            end
            bus(1'b1, aad_pkg::OFS_OPERAND, TB[i][7:0], 4'hF);
            ex = model(TB[i][31:24], e_acc, e_flg, TB[i][7:0]);
            bus(1'b1, aad_pkg::OFS_CMD, TB[i][31:24], 4'hF);
            cyc = 0;
            @(negedge clk_i);
            while (busy_o === 1'b1 && cyc < 40) begin
                cyc++;
                @(negedge clk_i);
            end
            e_len = (TB[i][31:24] == aad_pkg::OPC_SETC ||
                     TB[i][31:24] == aad_pkg::OPC_DADJ) ? 4 : 7;
            if (cyc >= 40) begin
                n_fail++;
                close_out();
            end
            check("t states", cyc, e_len);
            if (done_o !== 1'b1) begin
                @(negedge clk_i);
            end
            check("done", {31'h0, done_o}, 32'h1); // completion
            bus(1'b0, aad_pkg::OFS_ACC, 8'h00, 4'hF);
            check("acc", rd, {24'h0, ex[15:8]}); // result
            bus(1'b0, aad_pkg::OFS_FLAGS, 8'h00, 4'hF);
            check("flags", rd, {24'h0, ex[7:0]}); // flags
            check("flags pin", {24'h0, flags_o}, {24'h0, ex[7:0]});
            e_acc = ex[15:8];
            e_flg = ex[7:0];
        end
        close_out();
    end
endmodule

/* File: aad_pkg.sv */
// Shared constants, types and helpers of the accumulator ALU block
package aad_pkg;

    ////////////////////////////////////////////////////////////////////////
    // Timing
    localparam int CLK_PERIOD_NS = 10;
    localparam int TSTATE_NS = 10;
    // Clocks per T state, rounded up, at least one
    localparam int TSTATE_CYC_INT = (TSTATE_NS + CLK_PERIOD_NS - 1)
                                    / CLK_PERIOD_NS;
    localparam logic [3:0] TSTATE_CYC = 4'(TSTATE_CYC_INT);
    localparam logic [3:0] TST_SHORT = 4'h4; // Implied single-byte forms
    localparam logic [3:0] TST_IMM = 4'h7;   // Opcode plus operand byte

    ////////////////////////////////////////////////////////////////////////
    // Register byte offsets
    localparam logic [4:0] OFS_ACC = 5'h00;
    localparam logic [4:0] OFS_FLAGS = 5'h04;
    localparam logic [4:0] OFS_OPERAND = 5'h08;
    localparam logic [4:0] OFS_CMD = 5'h0C;
    localparam logic [4:0] OFS_STATUS = 5'h10;

    // Reset values
    localparam logic [7:0] ACC_RST = 8'h00;
    localparam logic [7:0] OPERAND_RST = 8'h00;
    localparam logic [7:0] CMD_RST = 8'h00;

    // Flag byte layout
    localparam int FLG_S = 7;
    localparam int FLG_Z = 6;
    localparam int FLG_H = 4;
    localparam int FLG_PV = 2;
    localparam int FLG_N = 1;
    localparam int FLG_C = 0;

    // Status layout
    localparam int STS_BUSY = 0;
    localparam int STS_ILLEGAL = 1;
    localparam int STS_TCNT_LSB = 4;

    ////////////////////////////////////////////////////////////////////////
    // Opcodes
    localparam logic [7:0] OPC_SETC = 8'h37;
    localparam logic [7:0] OPC_DADJ = 8'h27;
    localparam logic [7:0] OPC_ADD = 8'hC6;
    localparam logic [7:0] OPC_ADC = 8'hCE;
    localparam logic [7:0] OPC_SUB = 8'hD6;
    localparam logic [7:0] OPC_SUBB = 8'hDE;
    localparam logic [7:0] OPC_AND = 8'hE6;
    localparam logic [7:0] OPC_OR = 8'hF6;

    ////////////////////////////////////////////////////////////////////////
    // Types
    typedef enum logic [2:0] {
        OP_SETC, OP_DADJ, OP_ADD, OP_ADC, OP_SUB, OP_SUBB, OP_AND, OP_OR
    } aad_op_t;

    typedef struct packed {
        logic s;
        logic z;
        logic h;
        logic pv;
        logic n;
        logic c;
    } aad_flags_t;

    typedef struct packed {
        logic [7:0] acc;
        aad_flags_t flags;
    } aad_state_t;

    localparam aad_flags_t FLAGS_RST = '0;

    // Flag struct to byte, unused bits zero
    function automatic logic [7:0] flags_to_byte(input aad_flags_t f);
        logic [7:0] b;
        b = 8'h00;
        b[FLG_S] = f.s;
        b[FLG_Z] = f.z;
        b[FLG_H] = f.h;
        b[FLG_PV] = f.pv;
        b[FLG_N] = f.n;
        b[FLG_C] = f.c;
        return b;
    endfunction

    // Byte to flag struct
    function automatic aad_flags_t byte_to_flags(input logic [7:0] b);
        aad_flags_t f;
        f.s = b[FLG_S];
        f.z = b[FLG_Z];
        f.h = b[FLG_H];
        f.pv = b[FLG_PV];
        f.n = b[FLG_N];
        f.c = b[FLG_C];
        return f;
    endfunction

endpackage
